// ==== bench/crf_core_regs_properties.sv ====
/* port checker of the core register file.
   assumes binding onto crf_core_regs. */
`timescale 1ns/100ps
module crf_core_regs_properties (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // core side
  input wire logic ALU_UPD_I,
  input wire crf_pkg::crf_alu_t ALU_FLAGS_I,
  input wire logic CORE_NIP_WE_I,
  input wire logic [19:0] CORE_NIP_I,
  input wire logic IRQ_REQ_I,
  input wire logic IRQ_MASKABLE_I,
  input wire logic [2:0] IRQ_PRIO_I,
  input wire logic IRQ_ACK_I,
  input wire logic [19:0] MEM_ADR_I,
  // observed
  input wire logic [19:0] NEXT_INSTR_PTR_O,
  input wire logic [10:0] FLAG_WORD_O,
  input wire logic BANK_SEL_O,
  input wire logic IRQ_TAKE_O,
  input wire crf_pkg::crf_region_t MEM_REGION_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  // -----
  // properties
  // -----
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held");
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack");
  a_irq_take: assert property (IRQ_TAKE_O == (IRQ_REQ_I && (!IRQ_MASKABLE_I || FLAG_WORD_O[6])
    && (IRQ_PRIO_I > FLAG_WORD_O[10:8]))) else $error("take wrong");
  a_ie_clear: assert property (IRQ_ACK_I |=> !FLAG_WORD_O[6])
    else $error("enable kept");
  a_alu_flags: assert property (ALU_UPD_I |=> {FLAG_WORD_O[5], FLAG_WORD_O[3:2], FLAG_WORD_O[0]} ==
    {$past(ALU_FLAGS_I.ovf), $past(ALU_FLAGS_I.sign), $past(ALU_FLAGS_I.zero), $past(ALU_FLAGS_I.carry)})
    else $error("flags wrong");
  a_nip_load: assert property (CORE_NIP_WE_I |=> NEXT_INSTR_PTR_O == $past(CORE_NIP_I))
    else $error("pointer wrong");
  a_bank_sel: assert property (BANK_SEL_O == FLAG_WORD_O[4])
    else $error("bank wrong");
  a_region_map: assert property (MEM_REGION_O == {MEM_ADR_I <= 20'h0_02FF,
    MEM_ADR_I >= 20'h0_0400 && MEM_ADR_I <= 20'h0_0DFF, MEM_ADR_I >= 20'h0_2400 && MEM_ADR_I <= 20'h0_2BFF,
    MEM_ADR_I >= 20'h0_FFDC && MEM_ADR_I <= 20'h0_FFFF}) else $error("region wrong");
  c_bus_ack: cover property (WB_CYC_I && WB_ACK_O);
  c_irq_take: cover property (IRQ_TAKE_O);
  c_irq_ack: cover property (IRQ_ACK_I);
endmodule : crf_core_regs_properties

bind crf_core_regs crf_core_regs_properties u_props (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .ALU_UPD_I(ALU_UPD_I),
  .ALU_FLAGS_I(ALU_FLAGS_I), .CORE_NIP_WE_I(CORE_NIP_WE_I), .CORE_NIP_I(CORE_NIP_I),
  .IRQ_REQ_I(IRQ_REQ_I), .IRQ_MASKABLE_I(IRQ_MASKABLE_I), .IRQ_PRIO_I(IRQ_PRIO_I),
  .IRQ_ACK_I(IRQ_ACK_I), .MEM_ADR_I(MEM_ADR_I), .NEXT_INSTR_PTR_O(NEXT_INSTR_PTR_O),
  .FLAG_WORD_O(FLAG_WORD_O), .BANK_SEL_O(BANK_SEL_O), .IRQ_TAKE_O(IRQ_TAKE_O), .MEM_REGION_O(MEM_REGION_O));

// ==== bench/tb_cpu_register_file_flags.sv ====
/* self-checking bench of the core register file.
   assumes crf_pkg and the bound port checker. */
`timescale 1ns/100ps
module tb_cpu_register_file_flags;
  typedef struct packed {
    logic [7:0] a;
    logic [3:0] s;
    logic [31:0] d;
    logic [31:0] e;
  } crf_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic alu_upd = 1'b0;
  crf_pkg::crf_alu_t alu_f = '0;
  logic dw_we = 1'b0;
  logic [1:0] dw_sel = 2'h0;
  logic [1:0] dw_be = 2'h0;
  logic [15:0] dw_dat = 16'h0000;
  logic nip_we = 1'b0;
  logic [19:0] nip = 20'h0_0000;
  logic irq_req = 1'b0;
  logic irq_msk = 1'b0;
  logic irq_ack = 1'b0;
  logic swi_exec = 1'b0;
  logic [5:0] swi_num = 6'h00;
  logic [2:0] prio = 3'h0;
  logic [19:0] madr = 20'h0_0000;
  logic [31:0] dl0, dl1, al, q;
  logic [15:0] fbo, sbo, asp;
  logic [19:0] vtb, nipo;
  logic [10:0] cpu_flag_word;
  logic bank, take;
  crf_pkg::crf_region_t rgn;
  int failures = 0;
  int checks = 0;
  int cyc_n = 0;
  crf_row_t rows[13] = '{'{8'h00, 4'hF, 32'h1234_5678, 32'h0000_5678}, '{8'h08, 4'hF, 32'h0000_ABCD, 32'h0000_ABCD},
    '{8'h04, 4'hF, 32'h0000_1111, 32'h0000_1111}, '{8'h0C, 4'hF, 32'h0000_3333, 32'h0000_3333},
    '{8'h10, 4'hF, 32'h0000_A0A0, 32'h0000_A0A0}, '{8'h14, 4'hF, 32'h0000_A1A1, 32'h0000_A1A1},
    '{8'h18, 4'h1, 32'h0000_1234, 32'h0000_0034}, '{8'h1C, 4'hF, 32'h0000_5B5B, 32'h0000_5B5B},
    '{8'h20, 4'hF, 32'hFFFF_FFFF, 32'h000F_FFFF}, '{8'h24, 4'hF, 32'h0001_2345, 32'h0001_2345},
    '{8'h28, 4'hF, 32'h0000_7E7E, 32'h0000_7E7E},
    '{8'h2C, 4'hF, 32'h0000_1515, 32'h0000_1515}, '{8'h3C, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};
  logic [23:0] mt[8] = '{24'h00_2FF8, 24'h00_3000, 24'h00_4004, 24'h00_DFF4, 24'h00_E000, 24'h02_4002,
    24'h02_C000, 24'h0F_FDC1};

  always #5 clk = ~clk;

  crf_core_regs DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .ALU_UPD_I(alu_upd),
    .ALU_FLAGS_I(alu_f), .CORE_DW_WE_I(dw_we), .CORE_DW_SEL_I(dw_sel), .CORE_DW_BE_I(dw_be),
    .CORE_DW_DAT_I(dw_dat), .CORE_NIP_WE_I(nip_we), .CORE_NIP_I(nip), .IRQ_REQ_I(irq_req),
    .IRQ_MASKABLE_I(irq_msk), .IRQ_PRIO_I(prio), .IRQ_ACK_I(irq_ack), .SWI_EXEC_I(swi_exec), .SWI_NUM_I(swi_num),
    .DATA_LONG_ZERO_O(dl0), .DATA_LONG_ONE_O(dl1), .ADDRESS_LONG_O(al), .FRAME_BASE_O(fbo),
    .STATIC_BASE_O(sbo), .VECTOR_TABLE_BASE_O(vtb), .NEXT_INSTR_PTR_O(nipo), .ACTIVE_SP_O(asp),
    .FLAG_WORD_O(cpu_flag_word), .BANK_SEL_O(bank), .IRQ_TAKE_O(take), .MEM_ADR_I(madr), .MEM_REGION_O(rgn));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) dw_we <= 1'b1;
    if (k == 1) alu_upd <= 1'b1;
    if (k == 2) irq_ack <= 1'b1;
    if (k == 3) nip_we <= 1'b1;
    if (k == 4) swi_exec <= 1'b1;
    @(posedge clk);
    {dw_we, alu_upd, irq_ack, nip_we, swi_exec} <= 5'h00;
    @(posedge clk);
  endtask : pulse

  task automatic irq(input logic m, input logic [2:0] p, input logic e);
    irq_msk <= m;
    prio <= p;
    @(posedge clk);
    chk(32'(take), 32'(e));
  endtask : irq

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    chk(32'(cpu_flag_word), 32'h0000_0000);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wb(1'b1, rows[i].a, rows[i].s, rows[i].d, q);
      wb(1'b0, rows[i].a, 4'hF, 32'h0000_0000, q);
      chk(q, rows[i].e);
    end
    chk(dl1, 32'h3333_1111);
    chk(al, 32'hA1A1_A0A0);
    chk({fbo, sbo}, 32'h0034_5B5B);
    chk(32'(vtb), 32'h000F_FFFF);
    chk(32'(asp), 32'h0000_1515);
    dw_sel <= 2'h0;
    dw_be <= 2'b01;
    dw_dat <= 16'hAA55;
    pulse(0);
    chk(dl0, 32'hABCD_5655);
    nip <= 20'hF_FFDC;
    pulse(3);
    chk(32'(nipo), 32'h000F_FFDC);
    wb(1'b1, 8'h30, 4'hF, 32'h0000_0250, q);
    chk({bank, cpu_flag_word}, {1'b1, 11'h250});
    irq_req <= 1'b1;
    irq(1'b1, 3'h3, 1'b1);
    irq(1'b1, 3'h2, 1'b0);
    pulse(2);
    chk(32'(cpu_flag_word), 32'h0000_0210);
    irq(1'b1, 3'h7, 1'b0);
    irq(1'b0, 3'h3, 1'b1);
    irq(1'b0, 3'h2, 1'b0);
    alu_f <= '{1'b1, 1'b0, 1'b1, 1'b1};
    pulse(1);
    chk(32'(cpu_flag_word), 32'h0000_0239);
    alu_f <= '{1'b0, 1'b1, 1'b0, 1'b0};
    pulse(1);
    chk(32'(cpu_flag_word), 32'h0000_0214);
    wb(1'b1, 8'h30, 4'hF, 32'h0000_0080, q);
    chk(32'(asp), 32'h0000_7E7E);
    wb(1'b1, 8'h34, 4'h3, 32'h0000_6C6C, q);
    wb(1'b0, 8'h34, 4'hF, 32'h0000_0000, q);
    chk(q, 32'h0000_6C6C);
    swi_num <= 6'h20;
    pulse(4);
    chk(32'(cpu_flag_word), 32'h0000_0080);
    swi_num <= 6'h1F;
    pulse(4);
    chk(32'(cpu_flag_word), 32'h0000_0000);
    chk(32'(asp), 32'h0000_1515);
    foreach (mt[i]) begin
      madr <= mt[i][23:4];
      @(posedge clk);
      chk(32'(rgn), 32'(mt[i][3:0]));
    end
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(dl0, 32'h0000_0000);
    chk(32'(cpu_flag_word), 32'h0000_0000);
    finish_test();
  end
endmodule : tb_cpu_register_file_flags

// ==== logic/crf_core_regs.sv ====
/*
 * architectural register set and flag word of the core, with a classic
 * wishbone slave for access, a core side port for the decoder and alu,
 * interrupt acceptance and address region decode.
 * assumes a single clock and a synchronous active low reset.
 */
`timescale 1ns/100ps
`include "crf_consts.svh"

module crf_core_regs #(
  parameter int ADR_W = 8
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // alu flag update
  input wire logic ALU_UPD_I,
  input wire crf_pkg::crf_alu_t ALU_FLAGS_I,
  // core register write, byte lane access on data words
  input wire logic CORE_DW_WE_I,
  input wire logic [1:0] CORE_DW_SEL_I,
  input wire logic [1:0] CORE_DW_BE_I,
  input wire logic [15:0] CORE_DW_DAT_I,
  input wire logic CORE_NIP_WE_I,
  input wire logic [19:0] CORE_NIP_I,
  // interrupt request and acknowledge
  input wire logic IRQ_REQ_I,
  input wire logic IRQ_MASKABLE_I,
  input wire logic [2:0] IRQ_PRIO_I,
  input wire logic IRQ_ACK_I,
  input wire logic SWI_EXEC_I,
  input wire logic [5:0] SWI_NUM_I,
  // core visible values
  output logic [31:0] DATA_LONG_ZERO_O,
  output logic [31:0] DATA_LONG_ONE_O,
  output logic [31:0] ADDRESS_LONG_O,
  output logic [15:0] FRAME_BASE_O,
  output logic [15:0] STATIC_BASE_O,
  output logic [19:0] VECTOR_TABLE_BASE_O,
  output logic [19:0] NEXT_INSTR_PTR_O,
  output logic [15:0] ACTIVE_SP_O,
  output logic [10:0] FLAG_WORD_O,
  output logic BANK_SEL_O,
  output logic IRQ_TAKE_O,
  // address region decode
  input wire logic [19:0] MEM_ADR_I,
  output crf_pkg::crf_region_t MEM_REGION_O
);

  crf_pkg::crf_regs_t r_r;
  crf_pkg::crf_regs_t r_nxt;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] wmask;

  assign wr_stb = WB_CYC_I && WB_STB_I && WB_WE_I && (r_r.st == crf_pkg::CRF_ST_IDLE);
  assign rd_stb = WB_CYC_I && WB_STB_I && !WB_WE_I && (r_r.st == crf_pkg::CRF_ST_IDLE);
  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  function automatic logic [15:0] mrg16(input logic [15:0] old, input logic [31:0] d, input logic [31:0] m);
    mrg16 = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
  endfunction : mrg16

  function automatic logic [19:0] mrg20(input logic [19:0] old, input logic [31:0] d, input logic [31:0] m);
    mrg20 = (old & ~m[19:0]) | (d[19:0] & m[19:0]);
  endfunction : mrg20

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_nxt = r_r;
    // bus handshake: ack one cycle, then drop
    case (r_r.st)
      crf_pkg::CRF_ST_IDLE: begin
        if (WB_CYC_I && WB_STB_I) begin
          r_nxt.st = crf_pkg::CRF_ST_ACK;
        end
      end
      crf_pkg::CRF_ST_ACK: begin
        r_nxt.st = crf_pkg::CRF_ST_IDLE;
      end
      default: begin
        r_nxt.st = crf_pkg::CRF_ST_IDLE;
      end
    endcase

    // bus reads; unmapped reads zero
    if (rd_stb) begin
      if (WB_ADR_I == `CRF_ADR_DW0) begin
        r_nxt.rdat = {16'h0000, r_r.dw[0]};
      end else if (WB_ADR_I == `CRF_ADR_DW1) begin
        r_nxt.rdat = {16'h0000, r_r.dw[1]};
      end else if (WB_ADR_I == `CRF_ADR_DW2) begin
        r_nxt.rdat = {16'h0000, r_r.dw[2]};
      end else if (WB_ADR_I == `CRF_ADR_DW3) begin
        r_nxt.rdat = {16'h0000, r_r.dw[3]};
      end else if (WB_ADR_I == `CRF_ADR_AW0) begin
        r_nxt.rdat = {16'h0000, r_r.aw0};
      end else if (WB_ADR_I == `CRF_ADR_AW1) begin
        r_nxt.rdat = {16'h0000, r_r.aw1};
      end else if (WB_ADR_I == `CRF_ADR_FBP) begin
        r_nxt.rdat = {16'h0000, r_r.fbp};
      end else if (WB_ADR_I == `CRF_ADR_SBP) begin
        r_nxt.rdat = {16'h0000, r_r.sbp};
      end else if (WB_ADR_I == `CRF_ADR_VTB) begin
        r_nxt.rdat = {12'h000, r_r.vtb};
      end else if (WB_ADR_I == `CRF_ADR_NIP) begin
        r_nxt.rdat = {12'h000, r_r.nip};
      end else if (WB_ADR_I == `CRF_ADR_USP) begin
        r_nxt.rdat = {16'h0000, r_r.user_stack_pointer};
      end else if (WB_ADR_I == `CRF_ADR_ISP) begin
        r_nxt.rdat = {16'h0000, r_r.interrupt_stack_pointer};
      end else if (WB_ADR_I == `CRF_ADR_FLG) begin
        r_nxt.rdat = {21'h00_0000, r_r.cpu_flag_word & `CRF_FLG_WMASK};
      end else if (WB_ADR_I == `CRF_ADR_ASP) begin
        r_nxt.rdat = {16'h0000, ACTIVE_SP_O};
      end else begin
        r_nxt.rdat = 32'h0000_0000;
      end
    end

    // bus writes with byte lanes
    if (wr_stb) begin
      if (WB_ADR_I == `CRF_ADR_DW0) begin
        r_nxt.dw[0] = mrg16(r_r.dw[0], WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_DW1) begin
        r_nxt.dw[1] = mrg16(r_r.dw[1], WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_DW2) begin
        r_nxt.dw[2] = mrg16(r_r.dw[2], WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_DW3) begin
        r_nxt.dw[3] = mrg16(r_r.dw[3], WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_AW0) begin
        r_nxt.aw0 = mrg16(r_r.aw0, WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_AW1) begin
        r_nxt.aw1 = mrg16(r_r.aw1, WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_FBP) begin
        r_nxt.fbp = mrg16(r_r.fbp, WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_SBP) begin
        r_nxt.sbp = mrg16(r_r.sbp, WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_VTB) begin
        r_nxt.vtb = mrg20(r_r.vtb, WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_NIP) begin
        r_nxt.nip = mrg20(r_r.nip, WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_USP) begin
        r_nxt.user_stack_pointer = mrg16(r_r.user_stack_pointer, WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_ISP) begin
        r_nxt.interrupt_stack_pointer = mrg16(r_r.interrupt_stack_pointer, WB_DAT_I, wmask);
      end else if (WB_ADR_I == `CRF_ADR_FLG) begin
        r_nxt.cpu_flag_word = 11'(mrg16({5'h00, r_r.cpu_flag_word}, WB_DAT_I, wmask)) & `CRF_FLG_WMASK;
      end else if (WB_ADR_I == `CRF_ADR_ASP) begin
        if (r_r.cpu_flag_word[`CRF_FB_U]) begin
          r_nxt.user_stack_pointer = mrg16(r_r.user_stack_pointer, WB_DAT_I, wmask);
        end else begin
          r_nxt.interrupt_stack_pointer = mrg16(r_r.interrupt_stack_pointer, WB_DAT_I, wmask);
        end
      end
    end

    // core byte or word write on data words
    if (CORE_DW_WE_I) begin
      if (CORE_DW_BE_I[0]) begin
        r_nxt.dw[CORE_DW_SEL_I][7:0] = CORE_DW_DAT_I[7:0];
      end
      if (CORE_DW_BE_I[1]) begin
        r_nxt.dw[CORE_DW_SEL_I][15:8] = CORE_DW_DAT_I[15:8];
      end
    end

    if (CORE_NIP_WE_I) begin
      r_nxt.nip = CORE_NIP_I;
    end

    if (ALU_UPD_I) begin
      r_nxt.cpu_flag_word[`CRF_FB_C] = ALU_FLAGS_I.carry;
      r_nxt.cpu_flag_word[`CRF_FB_Z] = ALU_FLAGS_I.zero;
      r_nxt.cpu_flag_word[`CRF_FB_S] = ALU_FLAGS_I.sign;
      r_nxt.cpu_flag_word[`CRF_FB_O] = ALU_FLAGS_I.ovf;
    end

    if (IRQ_ACK_I) begin
      r_nxt.cpu_flag_word[`CRF_FB_I] = 1'b0;
    end
    // stack-select cleared on hw or low software interrupt
    if (IRQ_ACK_I || (SWI_EXEC_I && (SWI_NUM_I <= `CRF_SWI_MAX))) begin
      r_nxt.cpu_flag_word[`CRF_FB_U] = 1'b0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      r_r <= '{dw: '0, aw0: `CRF_W16_RST, aw1: `CRF_W16_RST, fbp: `CRF_W16_RST, sbp: `CRF_W16_RST,
               vtb: `CRF_W20_RST, nip: `CRF_W20_RST, user_stack_pointer: `CRF_W16_RST, interrupt_stack_pointer: `CRF_W16_RST,
               cpu_flag_word: `CRF_FLG_RST, rdat: 32'h0000_0000, st: crf_pkg::CRF_ST_IDLE};
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign WB_ACK_O = (r_r.st == crf_pkg::CRF_ST_ACK);
  assign WB_DAT_O = r_r.rdat;
  assign DATA_LONG_ZERO_O = {r_r.dw[2], r_r.dw[0]};
  assign DATA_LONG_ONE_O = {r_r.dw[3], r_r.dw[1]};
  assign ADDRESS_LONG_O = {r_r.aw1, r_r.aw0};
  assign FRAME_BASE_O = r_r.fbp;
  assign STATIC_BASE_O = r_r.sbp;
  assign VECTOR_TABLE_BASE_O = r_r.vtb;
  assign NEXT_INSTR_PTR_O = r_r.nip;
  assign ACTIVE_SP_O = r_r.cpu_flag_word[`CRF_FB_U] ? r_r.user_stack_pointer : r_r.interrupt_stack_pointer;
  assign FLAG_WORD_O = r_r.cpu_flag_word & `CRF_FLG_WMASK;
  assign BANK_SEL_O = r_r.cpu_flag_word[`CRF_FB_B];
  // enable gates maskables; strictly above level
  assign IRQ_TAKE_O = IRQ_REQ_I && (!IRQ_MASKABLE_I || r_r.cpu_flag_word[`CRF_FB_I])
                      && (IRQ_PRIO_I > r_r.cpu_flag_word[10:`CRF_FB_IPL_LO]);

  // peripheral area; vector table; flash and ram
  assign MEM_REGION_O.peri = (MEM_ADR_I <= `CRF_PERI_HI);
  assign MEM_REGION_O.ram = (MEM_ADR_I >= `CRF_RAM_LO) && (MEM_ADR_I <= `CRF_RAM_HI);
  assign MEM_REGION_O.dflash = (MEM_ADR_I >= `CRF_DFL_LO) && (MEM_ADR_I <= `CRF_DFL_HI);
  assign MEM_REGION_O.vectors = (MEM_ADR_I >= `CRF_VEC_LO) && (MEM_ADR_I <= `CRF_VEC_HI);

endmodule : crf_core_regs

// ==== pkg/crf_consts.svh ====
/*
 * constants of the core register file: register byte addresses, flag bit positions,
 * reset values and address map boundaries.
 * assumes inclusion by bare name from the design file.
 */
// Contract
// - four 16-bit data words; words zero and one also split into byte halves.
// - word two with zero forms long zero; three with one forms long one.
// - two 16-bit address words, pair forms 32-bit address long.
// - frame base and static base pointers are 16-bit registers.
// - vector table base register is 20 bits wide.
// - next instruction pointer is 20 bits wide.
// - two 16-bit stack pointers; stack-select 0 picks interrupt, 1 user.
// - stack-select cleared on hardware interrupt or software interrupt 0 to 31.
// - flag word is 11 bits wide.
// - carry flag captures ALU carry, borrow or shifted-out bit.
// - zero flag set when result is zero, else cleared.
// - sign flag set when result is negative, else cleared.
// - bank-select flag picks register bank 0 or 1.
// - overflow flag set on overflow, else cleared.
// - maskable interrupts blocked when interrupt enable is 0.
// - acknowledging an interrupt clears interrupt enable.
// - 3-bit priority level; interrupt taken only if strictly higher.
// - reserved flag bit written 0; read value undefined (reads 0 here).
// - peripheral area 00000h to 002FFh; unassigned addresses reserved.
// - fixed vector table decodes at 0FFDCh to 0FFFFh.
// - data flash decodes 02400h to 02BFFh; RAM starts at 00400h.
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH

// ----------------------------------------
// register byte addresses on the bus
// ----------------------------------------
`define CRF_ADR_DW0 8'h00
`define CRF_ADR_DW1 8'h04
`define CRF_ADR_DW2 8'h08
`define CRF_ADR_DW3 8'h0C
`define CRF_ADR_AW0 8'h10
`define CRF_ADR_AW1 8'h14
`define CRF_ADR_FBP 8'h18
`define CRF_ADR_SBP 8'h1C
`define CRF_ADR_VTB 8'h20
`define CRF_ADR_NIP 8'h24
`define CRF_ADR_USP 8'h28
`define CRF_ADR_ISP 8'h2C
`define CRF_ADR_FLG 8'h30
`define CRF_ADR_ASP 8'h34

// ----------------------------------------
// flag word bit positions
// ----------------------------------------
`define CRF_FB_C 0
`define CRF_FB_D 1
`define CRF_FB_Z 2
`define CRF_FB_S 3
`define CRF_FB_B 4
`define CRF_FB_O 5
`define CRF_FB_I 6
`define CRF_FB_U 7
// first bit above the word, bus reads it and all above as zero
`define CRF_FB_RSV 11
`define CRF_FB_IPL_LO 8
`define CRF_FLG_WMASK 11'h7_FF
`define CRF_FLG_RST 11'h0_00

// ----------------------------------------
// reset values and address map
// ----------------------------------------
`define CRF_W16_RST 16'h0000
`define CRF_W20_RST 20'h0_0000
`define CRF_SWI_MAX 6'h1F
`define CRF_PERI_LO 20'h0_0000
`define CRF_PERI_HI 20'h0_02FF
`define CRF_RAM_LO 20'h0_0400
`define CRF_RAM_HI 20'h0_0DFF
`define CRF_DFL_LO 20'h0_2400
`define CRF_DFL_HI 20'h0_2BFF
`define CRF_VEC_LO 20'h0_FFDC
`define CRF_VEC_HI 20'h0_FFFF

`endif

// ==== pkg/crf_pkg.sv ====
/*
 * types of the core register file.
 * assumes crf_consts.svh for the numeric constants.
 */
package crf_pkg;

  // alu result flags for one operation
  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic ovf;
  } crf_alu_t;

  // address map region decode
  typedef struct packed {
    logic peri;
    logic ram;
    logic dflash;
    logic vectors;
  } crf_region_t;

  typedef enum logic [1:0] {
    CRF_ST_IDLE = 2'b01,
    CRF_ST_ACK = 2'b10
  } crf_state_t;

  typedef struct packed {
    logic [3:0][15:0] dw;
    logic [15:0] aw0;
    logic [15:0] aw1;
    logic [15:0] fbp;
    logic [15:0] sbp;
    logic [19:0] vtb;
    logic [19:0] nip;
    logic [15:0] user_stack_pointer;
    logic [15:0] interrupt_stack_pointer;
    logic [10:0] cpu_flag_word;
    logic [31:0] rdat;
    crf_state_t st;
  } crf_regs_t;

endpackage : crf_pkg
